// ===== design/ufpic_top.sv
// Purpose: UART software flow control, FIFO triggers, power modes and interrupts
// Assumes: link words arrive and leave on i_link_clk; registers on i_clock
// Notes:   link domain ignores i_clk_en; crossings are toggle handshakes
`timescale 1ns/1ps
`include "ufpic_map.svh"
module ufpic_top #(
   parameter int unsigned CHAR_CYCLES = `UFPIC_CHAR_CYCLES,
   parameter int unsigned IDLE_CHARS  = `UFPIC_IDLE_CHARS
) (
   // Clock, reset, enable
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   input  wire logic       i_clk_en,
   // Register port
   input  wire logic [7:0] i_reg_addr,
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   input  wire logic [7:0] i_reg_wdata,
   output logic      [7:0] o_reg_rdata,
   output logic            o_reg_rvalid,
   // Pins
   input  wire logic [3:0] i_gpio,
   input  wire logic       i_rx_pin,
   input  wire logic       i_cts_n,
   input  wire logic       i_ext_clock,
   output logic            o_irq_n,
   // Link side
   input  wire logic       i_link_clk,
   input  wire logic       i_link_rx_valid,
   input  wire logic [7:0] i_link_rx_data,
   output logic            o_link_rx_ready,
   output logic            o_link_tx_valid,
   output logic      [7:0] o_link_tx_data,
   input  wire logic       i_link_tx_ready
);
   // Link domain: receive hold and transmit present
   logic       lrx_req_r;
   logic [7:0] lrx_data_r;
   logic [1:0] lrx_ack_s;
   logic [2:0] ltx_req_s;
   logic       ltx_ack_r;
   logic       crx_ack_r;
   logic       ctx_req_r;
   logic [7:0] ctx_data_r;
   always_ff @(posedge i_link_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         lrx_req_r       <= 1'b0;
         lrx_data_r      <= 8'h00;
         lrx_ack_s       <= 2'b00;
         o_link_rx_ready <= 1'b1;
         ltx_req_s       <= 3'b000;
         ltx_ack_r       <= 1'b0;
         o_link_tx_valid <= 1'b0;
         o_link_tx_data  <= 8'h00;
      end
      else
      begin
         lrx_ack_s <= {lrx_ack_s[0], crx_ack_r};
         ltx_req_s <= {ltx_req_s[1:0], ctx_req_r};
         if (o_link_rx_ready && i_link_rx_valid)
         begin
            lrx_data_r      <= i_link_rx_data;
            lrx_req_r       <= ~lrx_req_r;
            o_link_rx_ready <= 1'b0;
         end
         else if (!o_link_rx_ready && lrx_ack_s[1] == lrx_req_r)
            o_link_rx_ready <= 1'b1;
         if (ltx_req_s[2] != ltx_req_s[1])
         begin
            o_link_tx_valid <= 1'b1;
            o_link_tx_data  <= ctx_data_r;
         end
         else if (o_link_tx_valid && i_link_tx_ready)
         begin
            o_link_tx_valid <= 1'b0;
            ltx_ack_r       <= ~ltx_ack_r;
         end
      end
   end

   // Registers
   ufpic_pkg::ufpic_mode_s   mode_r;
   ufpic_pkg::ufpic_flow_s   flow_r;
   ufpic_pkg::ufpic_power_e  pw_r;
   ufpic_pkg::ufpic_rxflow_e rf_r;
   logic [7:0] top_mask_r, top_stat_r, line_mask_r, line_stat_r;
   logic [7:0] spc_mask_r, spc_flags_r, gsf_mask_r, gsf_flags_r;
   logic [7:0] trg_r, lvl_r, xon1_r, xon2_r, xoff1_r, xoff2_r;
   logic [7:0] rx_mem [0:127];
   logic [7:0] tx_mem [0:127];
   logic [6:0] rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
   logic [7:0] rx_cnt_r, tx_cnt_r, pw_cnt_r;
   logic [2:0] crx_req_s;
   logic [1:0] ctx_ack_s;
   logic       ctx_busy_r, cur_v_r, pend_v_r, pend_off_r, tx_halted_r;
   logic [7:0] cur_d_r, pend_d_r;
   logic [1:0] fc_left_r;
   logic       fc_off_r, ready_r, rx_trig_d_r, tx_trig_d_r, rx_emp_d_r, tx_emp_d_r;
   logic [6:0] pin_s1_r, pin_s2_r, pin_s3_r;
   logic [15:0] char_cnt_r;
   logic [16:0] idle_r;

   // Register decode
   wire        wr       = i_clk_en && i_reg_wr;
   wire        rd       = i_clk_en && i_reg_rd;
   wire        rd_hold  = rd && i_reg_addr == `UFPIC_A_HOLD;
   wire        rd_top   = rd && i_reg_addr == `UFPIC_A_TOP_STAT;
   wire        rd_spc   = rd && i_reg_addr == `UFPIC_A_SPC_FLAGS;
   wire        rd_gsf   = rd && i_reg_addr == `UFPIC_A_GSF_FLAGS;
   wire        wr_hold  = wr && i_reg_addr == `UFPIC_A_HOLD;
   wire        awake    = pw_r == ufpic_pkg::PW_RUN;
   wire        rx_empty = rx_cnt_r == 8'h00;
   wire        tx_empty = tx_cnt_r == 8'h00;
   wire        rx_full  = rx_cnt_r == `UFPIC_FIFO_DEPTH;
   wire        tx_full  = tx_cnt_r == `UFPIC_FIFO_DEPTH;
   wire [7:0]  rev_rd   = ready_r ? `UFPIC_REV_VALUE : 8'h00;
   wire [7:0]  hold_rd  = rx_empty ? 8'h00 : rx_mem[rx_rp_r];
   wire [7:0]  rd_mux   =
      (i_reg_addr == `UFPIC_A_HOLD)      ? hold_rd :
      (i_reg_addr == `UFPIC_A_TOP_MASK)  ? top_mask_r :
      (i_reg_addr == `UFPIC_A_TOP_STAT)  ? top_stat_r :
      (i_reg_addr == `UFPIC_A_LINE_MASK) ? line_mask_r :
      (i_reg_addr == `UFPIC_A_LINE_STAT) ? line_stat_r :
      (i_reg_addr == `UFPIC_A_SPC_MASK)  ? spc_mask_r :
      (i_reg_addr == `UFPIC_A_SPC_FLAGS) ? spc_flags_r :
      (i_reg_addr == `UFPIC_A_GSF_MASK)  ? gsf_mask_r :
      (i_reg_addr == `UFPIC_A_GSF_FLAGS) ? gsf_flags_r :
      (i_reg_addr == `UFPIC_A_MODE)      ? mode_r :
      (i_reg_addr == `UFPIC_A_FIFO_TRG)  ? trg_r :
      (i_reg_addr == `UFPIC_A_TX_LVL)    ? tx_cnt_r :
      (i_reg_addr == `UFPIC_A_RX_LVL)    ? rx_cnt_r :
      (i_reg_addr == `UFPIC_A_FLOW_CFG)  ? flow_r :
      (i_reg_addr == `UFPIC_A_FLOW_LVL)  ? lvl_r :
      (i_reg_addr == `UFPIC_A_XON1)      ? xon1_r :
      (i_reg_addr == `UFPIC_A_XON2)      ? xon2_r :
      (i_reg_addr == `UFPIC_A_XOFF1)     ? xoff1_r :
      (i_reg_addr == `UFPIC_A_XOFF2)     ? xoff2_r :
      (i_reg_addr == `UFPIC_A_REV_ID)    ? rev_rd : 8'h00;

   // Receive word classification
   wire tx_flow  = flow_r.tx_mode != 2'b00;
   wire tx_dual  = flow_r.tx_mode == 2'b11;
   wire rx_flow  = flow_r.rx_mode != 2'b00;
   wire rx_dual  = flow_r.rx_mode == 2'b11;
   wire crx_new  = crx_req_s[2] != crx_req_s[1];
   wire proc     = cur_v_r && awake;
   wire is_on1   = cur_d_r == xon1_r;
   wire is_off1  = cur_d_r == xoff1_r;
   wire pend_hit = pend_off_r ? (cur_d_r == xoff2_r) : (cur_d_r == xon2_r);
   wire single_hit = tx_flow && !tx_dual && (is_on1 || is_off1);
   wire pair_start = tx_flow && tx_dual && !pend_v_r && (is_on1 || is_off1);
   wire pair_done  = tx_flow && tx_dual && pend_v_r && pend_hit;
   wire pair_miss  = tx_flow && tx_dual && pend_v_r && !pend_hit;
   // matched flow words skip the FIFO; a broken pair pushes its held first word
   wire push_cur   = proc && !single_hit && !pair_start && !pair_done && !pair_miss;
   wire push_pend  = proc && pair_miss;
   wire take_cur   = proc && !pair_miss;
   wire rx_push    = (push_cur || push_pend) && !rx_full;
   wire [7:0] rx_wd = push_pend ? pend_d_r : cur_d_r;
   wire act_off    = (single_hit && is_off1) || (pair_done && pend_off_r);
   wire act_on     = (single_hit && is_on1) || (pair_done && !pend_off_r);
   wire spc_set    = push_cur && !tx_flow && (is_on1 || is_off1);
   wire rx_pop     = rd_hold && !rx_empty;

   // Transmit source selection
   wire ctx_free  = !ctx_busy_r && ctx_ack_s[1] == ctx_req_r;
   wire fc_send   = awake && ctx_free && !ctx_busy_r && fc_left_r != 2'b00;
   wire fc_first  = fc_left_r == 2'b10 || !rx_dual;
   wire [7:0] fc_char = fc_off_r ? (fc_first ? xoff1_r : xoff2_r)
                                 : (fc_first ? xon1_r : xon2_r);
   wire tx_pop    = awake && ctx_free && fc_left_r == 2'b00 && !tx_empty
                    && !mode_r.tx_disable && !tx_halted_r;
   wire tx_push   = wr_hold && !tx_full;
   // halt low nibble, resume high nibble
   wire [7:0] halt_lvl = {4'h0, lvl_r[3:0]};
   wire [7:0] res_lvl  = {4'h0, lvl_r[7:4]};
   // triggers use their own register only
   wire tx_trig = trg_r[3:0] != 4'h0 && tx_cnt_r >= {4'h0, trg_r[3:0]};
   wire rx_trig = trg_r[7:4] != 4'h0 && rx_cnt_r >= {4'h0, trg_r[7:4]};

   // Pins and power
   wire        activity  = pin_s2_r != pin_s3_r;
   wire        irq_pend  = |(top_stat_r & top_mask_r);
   wire        idle_done = idle_r == 17'(IDLE_CHARS);
   wire        char_end  = char_cnt_r == 16'(CHAR_CYCLES - 1);
   wire        auto_go   = mode_r.auto_sleep && rx_empty && tx_empty && !irq_pend && idle_done;
   wire        wake_done = pw_r == ufpic_pkg::PW_WAKE && pw_cnt_r == `UFPIC_STABLE_CYCLES;

   // Interrupt flag next values: set wins over clear
   // low bits summarise low-level registers
   wire [7:0] top_set = {
      pin_s3_r[5] != pin_s2_r[5],
      rx_empty && !rx_emp_d_r,
      tx_empty && !tx_emp_d_r,
      tx_trig && !tx_trig_d_r,
      rx_trig && !rx_trig_d_r,
      |(gsf_flags_r & gsf_mask_r),
      |(spc_flags_r & spc_mask_r),
      |(line_stat_r[5:0] & line_mask_r[5:0])};
   // read clears; transmit trigger also clears below level
   wire [7:0] top_clr = (rd_top ? 8'hff : 8'h00) | {3'b000, !tx_trig, 4'h0};
   wire [7:0] top_nxt = (top_stat_r & ~top_clr) | top_set;
   wire [7:0] spc_nxt = (spc_flags_r & ~(rd_spc ? 8'hff : 8'h00)) | {7'h00, spc_set};
   // no stability report with external clock
   wire       clk_ok  = wake_done && !pin_s2_r[6];
   wire [7:0] gsf_nxt = (gsf_flags_r & ~(rd_gsf ? 8'hff : 8'h00))
                        | {2'b00, clk_ok, 5'h00};

   // FIFO storage, no reset needed
   always_ff @(posedge i_clock)
   begin
      if (i_clk_en && rx_push)
         rx_mem[rx_wp_r] <= rx_wd;
      if (tx_push)
         tx_mem[tx_wp_r] <= i_reg_wdata;
   end

   // reset pin is shutdown: everything returns to defaults
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         mode_r <= 8'h00;  flow_r <= 8'h00;  trg_r <= 8'h00;  lvl_r <= 8'h00;
         xon1_r <= 8'h00;  xon2_r <= 8'h00;  xoff1_r <= 8'h00;  xoff2_r <= 8'h00;
         top_mask_r <= 8'h00;  line_mask_r <= 8'h00;
         spc_mask_r <= 8'h00;  gsf_mask_r <= 8'h00;
         top_stat_r <= `UFPIC_TOP_STAT_RST;
         spc_flags_r <= 8'h00;  gsf_flags_r <= 8'h00;  line_stat_r <= 8'h00;
         o_reg_rdata <= 8'h00;  o_reg_rvalid <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd)
            o_reg_rdata <= rd_mux;
         if (i_reg_wr)
         begin
            unique case (i_reg_addr)
               `UFPIC_A_TOP_MASK:  top_mask_r  <= i_reg_wdata;
               `UFPIC_A_LINE_MASK: line_mask_r <= {2'b00, i_reg_wdata[5:0]};
               `UFPIC_A_SPC_MASK:  spc_mask_r  <= i_reg_wdata;
               `UFPIC_A_GSF_MASK:  gsf_mask_r  <= i_reg_wdata;
               `UFPIC_A_MODE:      mode_r      <= i_reg_wdata;
               `UFPIC_A_FIFO_TRG:  trg_r       <= i_reg_wdata;
               `UFPIC_A_FLOW_CFG:  flow_r      <= i_reg_wdata;
               `UFPIC_A_FLOW_LVL:  lvl_r       <= i_reg_wdata;
               `UFPIC_A_XON1:      xon1_r      <= i_reg_wdata;
               `UFPIC_A_XON2:      xon2_r      <= i_reg_wdata;
               `UFPIC_A_XOFF1:     xoff1_r     <= i_reg_wdata;
               `UFPIC_A_XOFF2:     xoff2_r     <= i_reg_wdata;
               default:            ;
            endcase
         end
         // individually gated flags, cleared on read
         top_stat_r  <= top_nxt;
         spc_flags_r <= spc_nxt;
         gsf_flags_r <= gsf_nxt;
         // line status tracks live conditions only
         line_stat_r <= {!pin_s2_r[5], 5'h00, rx_full, 1'b0};
      end
   end

   // FIFO pointers, crossings, flow control
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rx_wp_r <= 7'h00;  rx_rp_r <= 7'h00;  rx_cnt_r <= 8'h00;
         tx_wp_r <= 7'h00;  tx_rp_r <= 7'h00;  tx_cnt_r <= 8'h00;
         crx_req_s <= 3'b000;  crx_ack_r <= 1'b0;  cur_v_r <= 1'b0;  cur_d_r <= 8'h00;
         ctx_ack_s <= 2'b00;  ctx_req_r <= 1'b0;  ctx_data_r <= 8'h00;  ctx_busy_r <= 1'b0;
         pend_v_r <= 1'b0;  pend_off_r <= 1'b0;  pend_d_r <= 8'h00;  tx_halted_r <= 1'b0;
         fc_left_r <= 2'b00;  fc_off_r <= 1'b0;  rf_r <= ufpic_pkg::RF_RUN;
         rx_trig_d_r <= 1'b0;  tx_trig_d_r <= 1'b0;  rx_emp_d_r <= 1'b1;  tx_emp_d_r <= 1'b1;
      end
      else if (i_clk_en)
      begin
         crx_req_s   <= {crx_req_s[1:0], lrx_req_r};
         ctx_ack_s   <= {ctx_ack_s[0], ltx_ack_r};
         rx_trig_d_r <= rx_trig;
         tx_trig_d_r <= tx_trig;
         rx_emp_d_r  <= rx_empty;
         tx_emp_d_r  <= tx_empty;
         if (crx_new)
         begin
            cur_v_r <= 1'b1;
            cur_d_r <= lrx_data_r;
         end
         else if (take_cur)
         begin
            cur_v_r   <= 1'b0;
            crx_ack_r <= ~crx_ack_r;
         end
         if (rx_push)
            rx_wp_r <= rx_wp_r + 7'h01;
         if (rx_pop)
            rx_rp_r <= rx_rp_r + 7'h01;
         rx_cnt_r <= rx_cnt_r + {7'h00, rx_push} - {7'h00, rx_pop};
         if (tx_push)
            tx_wp_r <= tx_wp_r + 7'h01;
         if (tx_pop)
            tx_rp_r <= tx_rp_r + 7'h01;
         tx_cnt_r <= tx_cnt_r + {7'h00, tx_push} - {7'h00, tx_pop};
         if (pair_start)
         begin
            pend_v_r   <= 1'b1;
            pend_off_r <= is_off1;
            pend_d_r   <= cur_d_r;
         end
         else if (pair_done || pair_miss)
            pend_v_r <= 1'b0;
         if (act_off)
            tx_halted_r <= 1'b1;
         else if (act_on || !tx_flow)
            tx_halted_r <= 1'b0;
         if (fc_send || tx_pop)
         begin
            ctx_req_r  <= ~ctx_req_r;
            ctx_data_r <= fc_send ? fc_char : tx_mem[tx_rp_r];
            ctx_busy_r <= 1'b1;
         end
         else if (ctx_busy_r && ctx_ack_s[1] == ctx_req_r)
            ctx_busy_r <= 1'b0;
         if (fc_send)
            fc_left_r <= fc_left_r - 2'b01;
         unique case (rf_r)
            ufpic_pkg::RF_RUN:
               if (rx_flow && fc_left_r == 2'b00 && rx_cnt_r >= halt_lvl)
               begin
                  rf_r      <= ufpic_pkg::RF_HALT;
                  fc_off_r  <= 1'b1;
                  fc_left_r <= rx_dual ? 2'b10 : 2'b01;
               end
            ufpic_pkg::RF_HALT:
               if (!rx_flow)
                  rf_r <= ufpic_pkg::RF_RUN;
               else if (fc_left_r == 2'b00 && rx_cnt_r <= res_lvl)
               begin
                  rf_r      <= ufpic_pkg::RF_RUN;
                  fc_off_r  <= 1'b0;
                  fc_left_r <= rx_dual ? 2'b10 : 2'b01;
               end
         endcase
      end
   end

   // Power sequencing, idle timing and the interrupt pin
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pw_r <= ufpic_pkg::PW_INIT;  pw_cnt_r <= 8'h00;  ready_r <= 1'b0;
         // Idle pin levels, so no false edge follows reset
         pin_s1_r <= 7'h30;  pin_s2_r <= 7'h30;  pin_s3_r <= 7'h30;
         char_cnt_r <= 16'h0000;  idle_r <= 17'h00000;
         o_irq_n <= 1'b0;
      end
      else if (i_clk_en)
      begin
         pin_s1_r <= {i_ext_clock, i_cts_n, i_rx_pin, i_gpio};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         // Idle only counts while the FIFOs are quiet
         if (activity || !rx_empty || !tx_empty)
         begin
            char_cnt_r <= 16'h0000;
            idle_r     <= 17'h00000;
         end
         else if (char_end)
         begin
            char_cnt_r <= 16'h0000;
            if (!idle_done)
               idle_r <= idle_r + 17'h00001;
         end
         else
            char_cnt_r <= char_cnt_r + 16'h0001;
         unique case (pw_r)
            ufpic_pkg::PW_INIT:
               if (pw_cnt_r == `UFPIC_INIT_CYCLES)
               begin
                  pw_r    <= ufpic_pkg::PW_RUN;
                  ready_r <= 1'b1;
               end
               else
                  pw_cnt_r <= pw_cnt_r + 8'h01;
            ufpic_pkg::PW_RUN:
               if (mode_r.forced_sleep || auto_go)
                  pw_r <= ufpic_pkg::PW_SLEEP;
            ufpic_pkg::PW_SLEEP:
               if (!mode_r.forced_sleep && (!mode_r.auto_sleep || activity))
               begin
                  pw_r     <= ufpic_pkg::PW_WAKE;
                  pw_cnt_r <= 8'h00;
               end
            ufpic_pkg::PW_WAKE:
               if (wake_done)
                  pw_r <= ufpic_pkg::PW_RUN;
               else
                  pw_cnt_r <= pw_cnt_r + 8'h01;
         endcase
         if (!ready_r)
            o_irq_n <= 1'b0;
         else if (mode_r.irq_sel)
            o_irq_n <= ~(|(top_nxt & top_mask_r));
         else
            o_irq_n <= 1'b1;
      end
   end
endmodule

// ===== include/ufpic_map.svh
`ifndef UFPIC_MAP_SVH
`define UFPIC_MAP_SVH
// Purpose: register offsets, field positions, reset values and counts
// Assumes: byte-wide registers at byte offsets
// Notes:   included by bare name
`define UFPIC_A_HOLD        8'h00
`define UFPIC_A_TOP_MASK    8'h01
`define UFPIC_A_TOP_STAT    8'h02
`define UFPIC_A_LINE_MASK   8'h03
`define UFPIC_A_LINE_STAT   8'h04
`define UFPIC_A_SPC_MASK    8'h05
`define UFPIC_A_SPC_FLAGS   8'h06
`define UFPIC_A_GSF_MASK    8'h07
`define UFPIC_A_GSF_FLAGS   8'h08
`define UFPIC_A_MODE        8'h09
`define UFPIC_A_FIFO_TRG    8'h0f
`define UFPIC_A_TX_LVL      8'h10
`define UFPIC_A_RX_LVL      8'h11
`define UFPIC_A_FLOW_CFG    8'h12
`define UFPIC_A_FLOW_LVL    8'h13
`define UFPIC_A_XON1        8'h14
`define UFPIC_A_XON2        8'h15
`define UFPIC_A_XOFF1       8'h16
`define UFPIC_A_XOFF2       8'h17
`define UFPIC_A_REV_ID      8'h1f
// Top status bit positions, then clock-stable, overrun and special-character flag bits
`define UFPIC_B_CTS         7
`define UFPIC_B_RX_EMPTY    6
`define UFPIC_B_TX_EMPTY    5
`define UFPIC_B_TX_TRIG     4
`define UFPIC_B_RX_TRIG     3
`define UFPIC_B_GSF         2
`define UFPIC_B_SPC         1
`define UFPIC_B_LINE        0
`define UFPIC_B_CLK_STABLE  5
`define UFPIC_B_OVERRUN     1
`define UFPIC_B_SPC_CHAR    0
`define UFPIC_TOP_STAT_RST  8'h60
// Arbitrary revision value, not tied to any part
`define UFPIC_REV_VALUE     8'h5a
`define UFPIC_FIFO_DEPTH    8'h80
`define UFPIC_INIT_CYCLES   8'h40
`define UFPIC_STABLE_CYCLES 8'h20
`define UFPIC_CHAR_CYCLES   400
`define UFPIC_IDLE_CHARS    65536
`endif

// ===== include/ufpic_pkg.sv
// Purpose: types shared by the flow, power and interrupt control block
// Assumes: constants live in ufpic_map.svh
// Notes:   mode and flow configuration travel as packed structs
package ufpic_pkg;
   typedef struct packed {
      logic       irq_sel;
      logic       auto_sleep;
      logic       forced_sleep;
      logic [2:0] spare_hi;
      logic       tx_disable;
      logic       spare_lo;
   } ufpic_mode_s;

   typedef struct packed {
      logic [1:0] rx_mode;
      logic [1:0] tx_mode;
      logic [3:0] other;
   } ufpic_flow_s;

   typedef enum logic [1:0] {PW_INIT, PW_RUN, PW_SLEEP, PW_WAKE} ufpic_power_e;
   typedef enum logic {RF_RUN, RF_HALT} ufpic_rxflow_e;
endpackage

// ===== sim/ufpic_link_model.sv
// Purpose: far-end UART seen as a word link
// Assumes: one word outstanding each way
// Notes:   ready toggling every link clock stalls the transmitter
`timescale 1ns/1ps
module ufpic_link_model (
   input  wire logic       i_link_clk,
   input  wire logic       i_ready,
   output logic            o_valid,
   output logic      [7:0] o_data,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   output logic            o_tx_ready = 1'b0
);
   logic [7:0] txq[$];
   initial {o_valid, o_data} = {1'b0, 8'h5c};
   // Released data is inverted so a stale word never matches
   task automatic send(input logic [7:0] d);
      while (i_ready !== 1'b1) @(posedge i_link_clk);
      #1 {o_valid, o_data} = {1'b1, d};
      do @(posedge i_link_clk); while (i_ready !== 1'b1);
      #1 {o_valid, o_data} = {1'b0, ~d};
      do @(posedge i_link_clk); while (i_ready !== 1'b1);
   endtask
   always @(posedge i_link_clk)
   begin
      if (i_tx_valid && o_tx_ready) txq.push_back(i_tx_data);
      o_tx_ready <= ~o_tx_ready;
   end
endmodule

// ===== sim/ufpic_top_chk.sv
// Purpose: port checks for the flow, power and interrupt block
// Assumes: both clock domains share the reset pin
// Notes:   ports packed several to a line to stay small
`timescale 1ns/1ps
`include "ufpic_map.svh"
module ufpic_top_chk #(parameter int unsigned CHAR_CYCLES = 4, IDLE_CHARS = 8) (
   // Core side
   input wire logic       i_clock, i_rst_n, i_clk_en, i_reg_rd, o_reg_rvalid, o_irq_n,
   input wire logic [7:0] i_reg_addr, o_reg_rdata,
   // Link side
   input wire logic       i_link_clk, i_link_rx_valid, o_link_rx_ready, o_link_tx_valid,
   input wire logic       i_link_tx_ready,
   input wire logic [7:0] o_link_tx_data
);
   // Saturates so a long run cannot wrap back into the init window
   logic [7:0] up_r;
   always_ff @(posedge i_clock or negedge i_rst_n)
      if (!i_rst_n) up_r <= 8'h00;
      else if (i_clk_en && up_r != 8'hff) up_r <= up_r + 8'h01;
   sequence s_rev_rd; i_reg_rd && i_clk_en && i_reg_addr == `UFPIC_A_REV_ID; endsequence
   sequence s_take; i_link_rx_valid && o_link_rx_ready; endsequence
   property p_init_low; @(posedge i_clock) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> !o_irq_n [*8]; endproperty
   property p_init_done; @(posedge i_clock) disable iff (!i_rst_n)
      up_r == 8'h64 |-> o_irq_n; endproperty
   property p_rd_ans; @(posedge i_clock) disable iff (!i_rst_n)
      i_reg_rd && i_clk_en |=> o_reg_rvalid; endproperty
   property p_rv_cause; @(posedge i_clock) disable iff (!i_rst_n)
      o_reg_rvalid |-> $past(i_reg_rd) && $past(i_clk_en); endproperty
   property p_rev; @(posedge i_clock) disable iff (!i_rst_n)
      s_rev_rd |=> o_reg_rdata == 8'h00 || o_reg_rdata == `UFPIC_REV_VALUE; endproperty
   property p_take; @(posedge i_link_clk) disable iff (!i_rst_n)
      s_take |=> !o_link_rx_ready; endproperty
   property p_tx_hold; @(posedge i_link_clk) disable iff (!i_rst_n)
      o_link_tx_valid && !i_link_tx_ready |=> o_link_tx_valid && $stable(o_link_tx_data);
   endproperty
   property p_link_rst; @(posedge i_link_clk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> !o_link_tx_valid; endproperty
   a_init_low: assert property (p_init_low) else $error("irq released early");
   a_init_done: assert property (p_init_done) else $error("irq still low");
   a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
   a_rv_cause: assert property (p_rv_cause) else $error("stray rvalid");
   a_rev: assert property (p_rev) else $error("bad revision value");
   a_take: assert property (p_take) else $error("rx ready held");
   a_tx_hold: assert property (p_tx_hold) else $error("tx word dropped");
   a_link_rst: assert property (p_link_rst) else $error("tx valid after reset");
endmodule
bind ufpic_top ufpic_top_chk #(.CHAR_CYCLES(CHAR_CYCLES), .IDLE_CHARS(IDLE_CHARS))
   ufpic_top_chk_i (.i_clock, .i_rst_n, .i_clk_en, .i_reg_rd, .o_reg_rvalid, .o_irq_n,
   .i_reg_addr, .o_reg_rdata, .i_link_clk, .i_link_rx_valid, .o_link_rx_ready,
   .o_link_tx_valid, .i_link_tx_ready, .o_link_tx_data);

// ===== sim/ufpic_top_tb.sv
// Purpose: self-checking bench for the flow, power and interrupt block
// Assumes: far-end link model drives the link side
// Notes:   data words keep bit 7 set so they never equal XON1 or XOFF1
`timescale 1ns/1ps
`include "ufpic_map.svh"
module ufpic_top_tb;
   logic        i_clock = 1'b0, link_clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, w, rx_data, tx_data;
   logic        rvalid, irq_n, rx_valid, rx_ready, tx_valid, tx_ready;
   logic        cts_n = 1'b1, ext_clk = 1'b0;
   logic [3:0]  gpio = 4'h0;
   logic [31:0] seed = 32'hd6e5;
   int          n_mismatch = 0, check_count = 0;
   always #12.5 i_clock = ~i_clock;
   always #15 link_clk = ~link_clk;
   ufpic_top #(.CHAR_CYCLES(4), .IDLE_CHARS(8)) ufpic_top_i (.i_clock, .i_rst_n(rst_n),
      .i_clk_en(1'b1), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_gpio(gpio), .i_rx_pin(1'b1),
      .i_cts_n(cts_n), .i_ext_clock(ext_clk), .o_irq_n(irq_n), .i_link_clk(link_clk),
      .i_link_rx_valid(rx_valid), .i_link_rx_data(rx_data), .o_link_rx_ready(rx_ready),
      .o_link_tx_valid(tx_valid), .o_link_tx_data(tx_data), .i_link_tx_ready(tx_ready));
   ufpic_link_model ufpic_link_model_i (.i_link_clk(link_clk), .i_ready(rx_ready),
      .o_valid(rx_valid), .o_data(rx_data), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
      .o_tx_ready(tx_ready));
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return {1'b1, seed[6:0]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      #2 {addr, wdata, wr} = {a, d, 1'b1};
      @(posedge i_clock);
      #2 wr = 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      @(posedge i_clock);
      #2 {addr, rd} = {a, 1'b1};
      @(posedge i_clock);
      #2 rd = 1'b0;
      chk(rvalid === 1'b1 ? rdata & m : 8'hxx, e);
   endtask
   task automatic expect_tx(input int n, input logic [7:0] e);
      for (int k = 0; k < 500 && ufpic_link_model_i.txq.size() <= n; k++) @(posedge i_clock);
      chk(ufpic_link_model_i.txq.size() > n ? ufpic_link_model_i.txq[n] : 8'hxx, e);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #100000 n_mismatch++;
      report_and_stop;
   end
   initial
   begin
      repeat (4) @(posedge i_clock);
      #2 rst_n = 1'b1;
      for (int k = 0; k < 300 && irq_n !== 1'b1; k++) @(posedge i_clock);
      repeat (80) @(posedge i_clock);
      chk({7'h00, irq_n}, 8'h01);
      rchk(`UFPIC_A_REV_ID, `UFPIC_REV_VALUE);
      rchk(`UFPIC_A_TOP_STAT, `UFPIC_TOP_STAT_RST);
      rchk(`UFPIC_A_TOP_STAT, 8'h00);
      $display("test init done");
      wreg(`UFPIC_A_MODE, 8'h02);
      wreg(`UFPIC_A_XON1, 8'h11);
      wreg(`UFPIC_A_XOFF1, 8'h13);
      wreg(`UFPIC_A_FLOW_CFG, 8'h10);
      wreg(`UFPIC_A_MODE, 8'h00);
      w = rnd();
      ufpic_link_model_i.send(w);
      ufpic_link_model_i.send(8'h13);
      rchk(`UFPIC_A_RX_LVL, 8'h01);
      rchk(`UFPIC_A_HOLD, w);
      rchk(`UFPIC_A_SPC_FLAGS, 8'h00);
      w = rnd();
      wreg(`UFPIC_A_HOLD, w);
      repeat (100) @(posedge i_clock);
      chk(8'(ufpic_link_model_i.txq.size()), 8'h00);
      ufpic_link_model_i.send(8'h11);
      expect_tx(0, w);
      $display("test tx flow done");
      wreg(`UFPIC_A_XON2, 8'h91);
      wreg(`UFPIC_A_XOFF2, 8'h93);
      wreg(`UFPIC_A_FLOW_LVL, 8'h13);
      wreg(`UFPIC_A_FIFO_TRG, 8'h20);
      wreg(`UFPIC_A_FLOW_CFG, 8'hc0);
      rchk(`UFPIC_A_TOP_STAT, 8'h00, 8'h08);
      for (int k = 0; k < 3; k++) ufpic_link_model_i.send(rnd());
      rchk(`UFPIC_A_TOP_STAT, 8'h08, 8'h08);
      expect_tx(1, 8'h13);
      expect_tx(2, 8'h93);
      rchk(`UFPIC_A_HOLD, 8'h80, 8'h80);
      rchk(`UFPIC_A_HOLD, 8'h80, 8'h80);
      expect_tx(3, 8'h11);
      expect_tx(4, 8'h91);
      $display("test rx flow done");
      wreg(`UFPIC_A_TOP_MASK, 8'h80);
      wreg(`UFPIC_A_MODE, 8'h80);
      cts_n = 1'b0;
      repeat (5) @(posedge i_clock);
      chk({7'h00, irq_n}, 8'h00);
      rchk(`UFPIC_A_LINE_STAT, 8'h80, 8'h80);
      rchk(`UFPIC_A_TOP_STAT, 8'h80, 8'h80);
      chk({7'h00, irq_n}, 8'h01);
      rchk(`UFPIC_A_LINE_STAT, 8'h80, 8'h80);
      w = rnd();
      wreg(`UFPIC_A_MODE, 8'h20);
      wreg(`UFPIC_A_HOLD, w);
      rchk(`UFPIC_A_REV_ID, `UFPIC_REV_VALUE);
      repeat (60) @(posedge i_clock);
      chk(8'(ufpic_link_model_i.txq.size()), 8'h05);
      wreg(`UFPIC_A_MODE, 8'h00);
      expect_tx(5, w);
      rchk(`UFPIC_A_GSF_FLAGS, 8'h20, 8'h20);
      ext_clk = 1'b1;
      rchk(`UFPIC_A_HOLD, 8'h80, 8'h80);
      wreg(`UFPIC_A_MODE, 8'h40);
      repeat (60) @(posedge i_clock);
      w = rnd();
      wreg(`UFPIC_A_HOLD, w);
      repeat (60) @(posedge i_clock);
      chk(8'(ufpic_link_model_i.txq.size()), 8'h06);
      #2 gpio = w[3:0] | 4'h1;
      expect_tx(6, w);
      rchk(`UFPIC_A_GSF_FLAGS, 8'h00, 8'h20);
      $display("test sleep done");
      rst_n = 1'b0;
      repeat (4) @(posedge i_clock);
      #2 rst_n = 1'b1;
      rchk(`UFPIC_A_MODE, 8'h00);
      rchk(`UFPIC_A_REV_ID, 8'h00);
      $display("test reset done");
      report_and_stop;
   end
endmodule
